/* include/eag_pkg.sv */
// package: modes, sizes and constants for the effective address generator
package eag_pkg;

  // ----------------------------------------------------------------
  // addressing modes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    EAG_MODE_REG_DIRECT = 3'h0,
    EAG_MODE_REG_IND    = 3'h1,
    EAG_MODE_POST_INC   = 3'h2,
    EAG_MODE_PRE_DEC    = 3'h3,
    EAG_MODE_DISP4      = 3'h4,
    EAG_MODE_INDEXED    = 3'h5,
    EAG_MODE_GBR_DISP8  = 3'h6
  } eag_mode_t;

  // ----------------------------------------------------------------
  // operand sizes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    EAG_SIZE_BYTE = 2'h0,
    EAG_SIZE_WORD = 2'h1,
    EAG_SIZE_LONG = 2'h2
  } eag_size_t;

  // ----------------------------------------------------------------
  // widths, reset values, step sizes and shift amounts
  // ----------------------------------------------------------------
  localparam int          EAG_ADDR_W     = 32;
  localparam int          EAG_DISP4_W    = 4;
  localparam int          EAG_DISP8_W    = 8;
  localparam logic [31:0] EAG_ADDR_RST   = 32'h0000_0000;
  localparam logic [31:0] EAG_STEP_BYTE  = 32'h0000_0001;
  localparam logic [31:0] EAG_STEP_WORD  = 32'h0000_0002;
  localparam logic [31:0] EAG_STEP_LONG  = 32'h0000_0004;
  localparam int          EAG_SHIFT_WORD = 1;
  localparam int          EAG_SHIFT_LONG = 2;

endpackage : eag_pkg

/* rtl/eag_scaler.sv */
// scaler: zero-extends a displacement and scales it by operand size
`timescale 1ns/1ps
module eag_scaler
  import eag_pkg::*;
#(
  parameter int DISP_W = 8
) (
  // displacement and operand size in
  input  wire logic [DISP_W-1:0] disp,
  input  wire eag_size_t         size,
  // scaled result and address step
  output logic [31:0]            scaled,
  output logic [31:0]            step
);

  logic [31:0] disp_ext;

  always_comb begin
    disp_ext = {{(32-DISP_W){1'b0}}, disp};
    case (size)
      EAG_SIZE_BYTE: begin
        scaled = disp_ext;
        step   = EAG_STEP_BYTE;
      end
      EAG_SIZE_WORD: begin
        scaled = disp_ext << EAG_SHIFT_WORD;
        step   = EAG_STEP_WORD;
      end
      default: begin
        scaled = disp_ext << EAG_SHIFT_LONG;
        step   = EAG_STEP_LONG;
      end
    endcase
  end

endmodule : eag_scaler

/* rtl/eag_top.sv */
// top: effective address generator datapath with registered outputs
`timescale 1ns/1ps
module eag_top
  import eag_pkg::*;
(
  // clock and reset
  input  wire logic        CORE_CLK,
  input  wire logic        RESET_N,
  input  wire logic        CLK_EN,
  // request from decoder
  input  wire logic        REQ_VALID,
  input  wire logic [2:0]  MODE,
  input  wire logic [1:0]  SIZE,
  input  wire logic [31:0] SELECTED_GENERAL_REGISTER,
  input  wire logic [31:0] GENERAL_REGISTER_ZERO,
  input  wire logic [31:0] GLOBAL_BASE_REGISTER,
  input  wire logic [7:0]  DISP,
  // answer to load/store unit
  output logic             RES_VALID,
  output logic             ADDR_VALID,
  output logic [31:0]      ADDR,
  output logic             OPERAND_VALID,
  output logic [31:0]      OPERAND,
  output logic             WB_VALID,
  output logic [31:0]      WB_DATA
);

  // ----------------------------------------------------------------
  // scaling
  // ----------------------------------------------------------------
  eag_mode_t   mode;
  eag_size_t   size;
  logic [31:0] scaled4;
  logic [31:0] scaled8;
  logic [31:0] step;

  assign mode = eag_mode_t'(MODE);
  assign size = eag_size_t'(SIZE);

  eag_scaler #(.DISP_W(EAG_DISP4_W)) u_scale4 (
    .disp   (DISP[EAG_DISP4_W-1:0]),
    .size   (size),
    .scaled (scaled4),
    .step   (step)
  );

  eag_scaler #(.DISP_W(EAG_DISP8_W)) u_scale8 (
    .disp   (DISP),
    .size   (size),
    .scaled (scaled8),
    .step   ()
  );

  // ----------------------------------------------------------------
  // next-value computation
  // ----------------------------------------------------------------
  logic        res_valid_reg, res_valid_next;
  logic        addr_valid_reg, addr_valid_next;
  logic [31:0] addr_reg, addr_next;
  logic        opnd_valid_reg, opnd_valid_next;
  logic [31:0] opnd_reg, opnd_next;
  logic        wb_valid_reg, wb_valid_next;
  logic [31:0] wb_data_reg, wb_data_next;

  always_comb begin
    res_valid_next  = REQ_VALID;
    addr_valid_next = 1'b0;
    addr_next       = addr_reg;
    opnd_valid_next = 1'b0;
    opnd_next       = opnd_reg;
    wb_valid_next   = 1'b0;
    wb_data_next    = wb_data_reg;
    if (REQ_VALID) begin
      addr_valid_next = 1'b1;
      case (mode)
        EAG_MODE_REG_DIRECT: begin
          addr_valid_next = 1'b0;
          opnd_valid_next = 1'b1;
          opnd_next       = SELECTED_GENERAL_REGISTER;
        end
        EAG_MODE_REG_IND: begin
          addr_next = SELECTED_GENERAL_REGISTER;
        end
        EAG_MODE_POST_INC: begin
          addr_next     = SELECTED_GENERAL_REGISTER;
          wb_valid_next = 1'b1;
          wb_data_next  = SELECTED_GENERAL_REGISTER + step;
        end
        EAG_MODE_PRE_DEC: begin
          addr_next     = SELECTED_GENERAL_REGISTER - step;
          wb_valid_next = 1'b1;
          wb_data_next  = SELECTED_GENERAL_REGISTER - step;
        end
        EAG_MODE_DISP4: begin
          addr_next = SELECTED_GENERAL_REGISTER + scaled4;
        end
        EAG_MODE_INDEXED: begin
          addr_next = SELECTED_GENERAL_REGISTER + GENERAL_REGISTER_ZERO;
        end
        EAG_MODE_GBR_DISP8: begin
          addr_next = GLOBAL_BASE_REGISTER + scaled8;
        end
        default: begin
          addr_valid_next = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge CORE_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      res_valid_reg  <= 1'b0;
      addr_valid_reg <= 1'b0;
      addr_reg       <= EAG_ADDR_RST;
      opnd_valid_reg <= 1'b0;
      opnd_reg       <= EAG_ADDR_RST;
      wb_valid_reg   <= 1'b0;
      wb_data_reg    <= EAG_ADDR_RST;
    end else if (CLK_EN) begin
      res_valid_reg  <= res_valid_next;
      addr_valid_reg <= addr_valid_next;
      addr_reg       <= addr_next;
      opnd_valid_reg <= opnd_valid_next;
      opnd_reg       <= opnd_next;
      wb_valid_reg   <= wb_valid_next;
      wb_data_reg    <= wb_data_next;
    end
  end

  assign RES_VALID     = res_valid_reg;
  assign ADDR_VALID    = addr_valid_reg;
  assign ADDR          = addr_reg;
  assign OPERAND_VALID = opnd_valid_reg;
  assign OPERAND       = opnd_reg;
  assign WB_VALID      = wb_valid_reg;
  assign WB_DATA       = wb_data_reg;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RESET_N);

  AST_DIRECT_NO_ADDR: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h0 |=> !ADDR_VALID && OPERAND_VALID
      && OPERAND == $past(SELECTED_GENERAL_REGISTER))
    else $error("direct mode produced an address");

  AST_IND_ADDR: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h1 |=> ADDR_VALID && !WB_VALID
      && ADDR == $past(SELECTED_GENERAL_REGISTER))
    else $error("indirect address wrong or write-back seen");

  AST_POST_INC: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h2 && SIZE == 2'h2 |=> WB_VALID
      && ADDR == $past(SELECTED_GENERAL_REGISTER)
      && WB_DATA == $past(SELECTED_GENERAL_REGISTER) + 32'h0000_0004)
    else $error("post-increment longword wrong");

  AST_PRE_DEC: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h3 && SIZE == 2'h1 |=> WB_VALID
      && ADDR == WB_DATA
      && ADDR == $past(SELECTED_GENERAL_REGISTER) - 32'h0000_0002)
    else $error("pre-decrement word wrong");

  AST_DISP4: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h4 && SIZE == 2'h2 |=>
      ADDR == $past(SELECTED_GENERAL_REGISTER) + {26'h0, $past(DISP[3:0]), 2'h0})
    else $error("displaced address wrong");

  AST_INDEXED: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h5 |=> !WB_VALID
      && ADDR == $past(SELECTED_GENERAL_REGISTER) + $past(GENERAL_REGISTER_ZERO))
    else $error("indexed address wrong");

  AST_GBR_DISP8: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h6 && SIZE == 2'h1 |=>
      ADDR == $past(GLOBAL_BASE_REGISTER) + {23'h0, $past(DISP), 1'b0})
    else $error("global base address wrong");

  AST_WRAP: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h2 && SIZE == 2'h0
      && SELECTED_GENERAL_REGISTER == 32'hFFFF_FFFF |=> WB_DATA == 32'h0000_0000)
    else $error("increment did not wrap");

  AST_FREEZE: assert property (
    !CLK_EN |=> $stable(ADDR) && $stable(RES_VALID))
    else $error("state moved while clock enable low");

  AST_IDLE_QUIET: assert property (
    CLK_EN && !REQ_VALID |=> !RES_VALID && !ADDR_VALID && !OPERAND_VALID && !WB_VALID)
    else $error("answer flags raised without a request");

  AST_DISP4_BYTE: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h4 && SIZE == 2'h0 |=> ADDR_VALID && !WB_VALID
      && ADDR == $past(SELECTED_GENERAL_REGISTER) + {28'h0, $past(DISP[3:0])})
    else $error("byte displaced address wrong");

  AST_GBR_LONG: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h6 && SIZE == 2'h2 |=> ADDR_VALID && !WB_VALID
      && ADDR == $past(GLOBAL_BASE_REGISTER) + {22'h0, $past(DISP), 2'h0})
    else $error("longword global base address wrong");

  AST_POST_INC_BYTE: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h2 && SIZE == 2'h0 |=> WB_VALID
      && ADDR == $past(SELECTED_GENERAL_REGISTER)
      && WB_DATA == $past(SELECTED_GENERAL_REGISTER) + 32'h0000_0001)
    else $error("post-increment byte wrong");

  AST_PRE_DEC_LONG: assert property (
    CLK_EN && REQ_VALID && MODE == 3'h3 && SIZE == 2'h2 |=> WB_VALID
      && ADDR == WB_DATA
      && ADDR == $past(SELECTED_GENERAL_REGISTER) - 32'h0000_0004)
    else $error("pre-decrement longword wrong");

  COV_POST_INC: cover property (CLK_EN && REQ_VALID && MODE == 3'h2);
  COV_PRE_DEC:  cover property (CLK_EN && REQ_VALID && MODE == 3'h3);
  COV_GBR:      cover property (CLK_EN && REQ_VALID && MODE == 3'h6);
  COV_DIRECT:   cover property (CLK_EN && REQ_VALID && MODE == 3'h0);
  COV_INDEXED:  cover property (CLK_EN && REQ_VALID && MODE == 3'h5);

endmodule : eag_top

/* testbench/eag_regfile_model.sv */
// model: register holder on the decoder side that applies write-back
`timescale 1ns/1ps
module eag_regfile_model (
  // clock
  input  wire logic        clk,
  // preload from bench
  input  wire logic        load_en,
  input  wire logic [31:0] load_val,
  // write-back from generator
  input  wire logic        wb_valid,
  input  wire logic [31:0] wb_data,
  // selected register value
  output logic [31:0]      reg_val
);
  // preload on the rising edge; write-back lands off the sampling edge,
  // ready for the next request; one process so the value has one driver
  always @(posedge clk or negedge clk) begin
    if (clk) begin
      if (load_en) begin
        reg_val <= load_val;
      end
    end else if (wb_valid) begin
      reg_val <= wb_data;
    end
  end
endmodule : eag_regfile_model

/* testbench/effective_address_generator_tb.sv */
// testbench: self-checking scenarios for the effective address generator
`timescale 1ns/1ps
module effective_address_generator_tb;
  import eag_pkg::*;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        en = 1'b1;
  logic        req = 1'b0;
  logic [2:0]  mode = 3'h0;
  logic [1:0]  size = 2'h0;
  logic [31:0] rn;
  logic [31:0] r0 = 32'hF000_0010;
  logic [31:0] global_base_register = 32'h8000_0000;
  logic [31:0] ld_val = 32'h0000_0000;
  logic [7:0]  disp = 8'hFF;
  logic        ld_en = 1'b0;
  logic        res_v, addr_v, op_v, wb_v;
  logic [31:0] addr, op, wbd;
  int          n_fail = 0;
  int          n_tests = 0;

  initial begin
    forever #50 clk = ~clk;
  end

  eag_top DUT (.CORE_CLK(clk), .RESET_N(rst_n), .CLK_EN(en), .REQ_VALID(req), .MODE(mode),
    .SIZE(size), .SELECTED_GENERAL_REGISTER(rn), .GENERAL_REGISTER_ZERO(r0),
    .GLOBAL_BASE_REGISTER(global_base_register), .DISP(disp), .RES_VALID(res_v), .ADDR_VALID(addr_v),
    .ADDR(addr), .OPERAND_VALID(op_v), .OPERAND(op), .WB_VALID(wb_v), .WB_DATA(wbd));

  eag_regfile_model u_model (.clk(clk), .load_en(ld_en), .load_val(ld_val),
    .wb_valid(wb_v), .wb_data(wbd), .reg_val(rn));

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH %s expected %08h seen %08h", name, exp, seen);
    end
  endtask : check

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : wrap_up

  task automatic load(input logic [31:0] v);
    ld_en = 1'b1;
    ld_val = v;
    @(negedge clk);
    ld_en = 1'b0;
    @(negedge clk);
  endtask : load

  // drive one request, return after the answering edge has landed
  task automatic issue(input logic [2:0] m, input logic [1:0] s);
    req = 1'b1;
    mode = m;
    size = s;
    @(negedge clk);
  endtask : issue

  task automatic idle();
    req = 1'b0;
    @(negedge clk);
  endtask : idle

  task automatic t_direct();
    load(32'h1234_5678);
    issue(3'h0, 2'h2);
    check("op_v", {31'h0, op_v}, 32'h1);
    check("operand", op, 32'h1234_5678);
    check("addr_v", {31'h0, addr_v}, 32'h0);
    issue(3'h7, 2'h0);
    check("res_v", {31'h0, res_v}, 32'h1);
    check("no_addr", {30'h0, addr_v, op_v}, 32'h0);
    idle();
    check("res_idle", {31'h0, res_v}, 32'h0);
  endtask : t_direct

  task automatic t_plain();
    for (int s = 0; s < 3; s++) begin
      load(32'h1000_0000);
      issue(3'h1, s[1:0]);
      check("ind", addr, 32'h1000_0000);
      check("ind_wb", {31'h0, wb_v}, 32'h0);
      check("ind_v", {31'h0, addr_v}, 32'h1);
      issue(3'h4, s[1:0]);
      check("disp4", addr, 32'h1000_0000 + (32'hF << s));
      issue(3'h5, s[1:0]);
      check("idx", addr, 32'h0000_0010);
      check("idx_wb", {31'h0, wb_v}, 32'h0);
      issue(3'h6, s[1:0]);
      check("gbr8", addr, 32'h8000_0000 + (32'hFF << s));
      idle();
    end
  endtask : t_plain

  task automatic t_incdec();
    logic [31:0] st;
    for (int s = 0; s < 3; s++) begin
      st = 32'h1 << s;
      load(32'hFFFF_FFFE);
      issue(3'h2, s[1:0]);
      check("pinc_a", addr, 32'hFFFF_FFFE);
      check("pinc_wb", wbd, 32'hFFFF_FFFE + st);
      issue(3'h3, s[1:0]);
      check("pdec_a", addr, 32'hFFFF_FFFE);
      check("pdec_wb", wbd, 32'hFFFF_FFFE);
      issue(3'h3, s[1:0]);
      check("pdec2", addr, 32'hFFFF_FFFE - st);
      check("pdec2_v", {31'h0, wb_v}, 32'h1);
      idle();
    end
    load(32'hFFFF_FFFF);
    issue(3'h2, 2'h0);
    check("wrap_a", addr, 32'hFFFF_FFFF);
    check("wrap_wb", wbd, 32'h0000_0000);
    idle();
  endtask : t_incdec

  task automatic t_freeze();
    load(32'h0000_0040);
    issue(3'h1, 2'h0);
    idle();
    en = 1'b0;
    issue(3'h6, 2'h2);
    check("frz_v", {31'h0, res_v}, 32'h0);
    check("frz_a", addr, 32'h0000_0040);
    en = 1'b1;
    @(negedge clk);
    check("run_a", addr, 32'h8000_03FC);
    idle();
  endtask : t_freeze

  // reset in mid-run clears every output; a request on the first edge after release is taken
  task automatic t_reset();
    load(32'h0000_0100);
    issue(3'h2, 2'h2);
    rst_n = 1'b0;
    idle();
    check("rst_flags", {28'h0, res_v, addr_v, op_v, wb_v}, 32'h0);
    check("rst_addr", addr, 32'h0);
    check("rst_op", op, 32'h0);
    check("rst_wbd", wbd, 32'h0);
    load(32'h0000_0200);
    rst_n = 1'b1;
    issue(3'h1, 2'h0);
    check("rel_a", addr, 32'h0000_0200);
    check("rel_v", {31'h0, addr_v}, 32'h1);
    idle();
  endtask : t_reset

  initial begin
    repeat (2000) @(posedge clk);
    n_fail++;
    wrap_up();
  end

  initial begin
    repeat (8) @(negedge clk);
    check("rst_a", addr, 32'h0);
    check("rst_v", {28'h0, res_v, addr_v, op_v, wb_v}, 32'h0);
    rst_n = 1'b1;
    @(negedge clk);
    t_direct();
    t_plain();
    t_incdec();
    t_freeze();
    t_reset();
    wrap_up();
  end
endmodule : effective_address_generator_tb
